//--- hw/trs_pkg.sv
// Constants shared by the trap and reset status block
package trs_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // Register byte offsets
    localparam logic [11:0] TRAP_CTRL_OFS   = 12'h000;
    localparam logic [11:0] RESET_CAUSE_OFS = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFS  = 12'h008;
    localparam logic [11:0] IRQ_ENABLE_OFS  = 12'h00c;
    localparam logic [11:0] IRQ_CLEAR_OFS   = 12'h010;

    // trap_control_status fields
    localparam int NEST_DIS_BIT  = 15;
    localparam int ACC_A_OVF_BIT = 14;
    localparam int ACC_B_OVF_BIT = 13;
    localparam int ACC_A_CAT_BIT = 12;
    localparam int ACC_B_CAT_BIT = 11;
    localparam int ACC_A_TE_BIT  = 10;
    localparam int ACC_B_TE_BIT  = 9;
    localparam int CAT_TE_BIT    = 8;
    localparam int SHIFT_ERR_BIT = 7;
    localparam int DIV_ZERO_BIT  = 6;
    localparam int DMA_TRAP_BIT  = 5;
    localparam int MATH_ERR_BIT  = 4;
    localparam int ADDR_ERR_BIT  = 3;
    localparam int STACK_ERR_BIT = 2;
    localparam int OSC_FAIL_BIT  = 1;
    localparam logic [15:0] TRAP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TRAP_CTRL_MASK  = 16'hfffe;
    localparam logic [15:0] TRAP_FLAG_MASK  = 16'h78fe;

    // reset_cause_flags fields
    localparam int WDT_SW_EN_BIT = 5;
    localparam int SLEEP_BIT     = 3;
    localparam int IDLE_BIT      = 2;
    localparam int BROWNOUT_BIT  = 1;
    localparam int POWER_ON_BIT  = 0;
    localparam logic [15:0] RESET_CAUSE_RESET = 16'h0001;
    localparam logic [15:0] RESET_CAUSE_MASK  = 16'h002f;

    // Interrupt events
    localparam int NUM_EVENTS  = 7;
    localparam int EV_MATH     = 0;
    localparam int EV_ADDR     = 1;
    localparam int EV_STACK    = 2;
    localparam int EV_OSC      = 3;
    localparam int EV_DMA      = 4;
    localparam int EV_BROWNOUT = 5;
    localparam int EV_WAKE     = 6;
    localparam logic [6:0] IRQ_ENABLE_RESET = 7'h00;

    // Synchronised pins: brownout, oscillator fail, watchdog config
    localparam int SYNC_W = 3;
    localparam logic [2:0] SYNC_RESET = 3'h4;

endpackage

//--- hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] dout_o
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

            // Change accepted once stages two and three agree
            always_comb begin
                lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
            end

            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_q  <= RESET_VAL[i];
                    s2_q  <= RESET_VAL[i];
                    s3_q  <= RESET_VAL[i];
                    lvl_q <= RESET_VAL[i];
                end else begin
                    s1_q  <= din_i[i];
                    s2_q  <= s1_q;
                    s3_q  <= s2_q;
                    lvl_q <= lvl_d;
                end
            end

            assign dout_o[i] = lvl_q;
        end
    endgenerate
endmodule // pin_sync

//--- hw/event_irq.sv
// Sticky event status, enable and clear with one interrupt line
`timescale 1ns/1ps
module event_irq #(
    parameter int N = 7
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic         clear_wr_i,
    input  wire logic         enable_wr_i,
    input  wire logic [N-1:0] wdata_i,
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] enable_o,
    output logic              irq_o
);
    logic [N-1:0] status_q, status_d;
    logic [N-1:0] enable_q, enable_d;
    logic         irq_q, irq_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        status_d = status_q & ~(clear_wr_i ? wdata_i : '0);
        status_d = status_d | set_i;
        enable_d = enable_wr_i ? wdata_i : enable_q;
        irq_d    = |(status_d & enable_d);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= '0;
            enable_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            enable_q <= enable_d;
            irq_q    <= irq_d;
        end
    end

    assign status_o = status_q;
    assign enable_o = enable_q;
    assign irq_o    = irq_q;
endmodule // event_irq

//--- hw/trap_and_reset_status.sv
// Trap control, reset cause and wake flags behind an APB slave
//
// What this block does
// RULE1: Trap bit 15 nests off, 14/13 A/B overflow, 12/11 A/B catastrophic.
// RULE2: Trap bits 7..1: shift, divide, DMA, math, address, stack, osc fail.
// RULE3: A catastrophic overflow trap of accumulator A sets trap bit 12.
// RULE4: Trap bit 10 enables the accumulator A overflow trap.
// RULE5: A math trap from an invalid accumulator shift sets trap bit 7.
// RULE6: A math trap from a divide by zero sets trap bit 6.
// RULE7: The trap register resets to zero and bit 0 always reads zero.
// RULE8: Having been in Sleep sets reset-cause bit 3.
// RULE9: Having been in Idle sets reset-cause bit 2.
// RULE10: A brown-out reset sets reset-cause bit 1.
// RULE11: A power-on reset sets reset-cause bit 0.
// RULE12: Software may set or clear reset flags; a write never resets.
// RULE13: An unprogrammed watchdog config bit keeps the watchdog on.
// RULE14: Trap flags stay set until software writes them to zero.
// RULE15: Nesting disable holds off requests during service.
`timescale 1ns/1ps
module trap_and_reset_status
    import trs_pkg::*;
#(
    parameter int PRIO_W = 3
) (
    input  wire logic                      MCLK_I,
    input  wire logic                      RESET_N_I,
    input  wire logic                      PSEL_I,
    input  wire logic                      PENABLE_I,
    input  wire logic                      PWRITE_I,
    input  wire logic [trs_pkg::ADDR_W-1:0] PADDR_I,
    input  wire logic [trs_pkg::DATA_W-1:0] PWDATA_I,
    output logic      [trs_pkg::DATA_W-1:0] PRDATA_O,
    output logic                           PREADY_O,
    output logic                           PSLVERR_O,
    input  wire logic                      ACC_A_OVF_I,
    input  wire logic                      ACC_B_OVF_I,
    input  wire logic                      ACC_A_CAT_I,
    input  wire logic                      ACC_B_CAT_I,
    input  wire logic                      SHIFT_ERR_I,
    input  wire logic                      DIV_ZERO_I,
    input  wire logic                      DMA_TRAP_I,
    input  wire logic                      ADDR_ERR_I,
    input  wire logic                      STACK_ERR_I,
    input  wire logic                      OSC_FAIL_I,
    input  wire logic                      BROWNOUT_I,
    input  wire logic                      SLEEP_WAKE_I,
    input  wire logic                      IDLE_WAKE_I,
    input  wire logic                      WDT_CONFIG_EN_I,
    input  wire logic                      IRQ_REQ_I,
    input  wire logic [PRIO_W-1:0]         IRQ_PRIO_I,
    input  wire logic                      IN_SERVICE_I,
    input  wire logic [PRIO_W-1:0]         SERVICE_PRIO_I,
    output logic                           IRQ_GRANT_O,
    output logic                           TRAP_REQ_O,
    output logic                           WATCHDOG_EN_O,
    output logic                           IRQ_O
);
    import trs_pkg::*;

    // APB state
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic              pready_q, pready_d;
    logic              pslverr_q, pslverr_d;

    // Register state
    logic [REG_W-1:0]  trap_q, trap_d;
    logic [REG_W-1:0]  cause_q, cause_d;
    logic [REG_W-1:0]  trap_set;

    // Derived outputs
    logic              grant_q, grant_d;
    logic              trap_req_q, trap_req_d;
    logic              wdt_en_q, wdt_en_d;

    // Edge detection on filtered pins
    logic              bor_prev_q, bor_prev_d;
    logic              osc_prev_q, osc_prev_d;
    logic              bor_rise, osc_rise;

    // Synchronised pins
    logic [SYNC_W-1:0] pin_raw, pin_lvl;
    logic              bor_lvl, osc_lvl, wdt_cfg_lvl;

    // Bus decode
    logic              setup, access, wr;
    logic              aligned, hit;
    logic              wr_trap, wr_cause, wr_en, wr_clr;
    logic [REG_W-1:0]  wdata16;
    logic [NUM_EVENTS-1:0] ev_set, ev_status, ev_enable;
    logic              irq_int;
    logic              math_set;

    assign pin_raw = {WDT_CONFIG_EN_I, OSC_FAIL_I, BROWNOUT_I};

    pin_sync #(
        .W         (SYNC_W),
        .RESET_VAL (SYNC_RESET)
    ) u_pin_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RESET_N_I),
        .din_i   (pin_raw),
        .dout_o  (pin_lvl)
    );

    assign bor_lvl     = pin_lvl[0];
    assign osc_lvl     = pin_lvl[1];
    assign wdt_cfg_lvl = pin_lvl[2];

    // Pin edge detection
    always_comb begin
        bor_rise   = bor_lvl & ~bor_prev_q;
        osc_rise   = osc_lvl & ~osc_prev_q;
        bor_prev_d = bor_lvl;
        osc_prev_d = osc_lvl;
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            bor_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            bor_prev_q <= bor_prev_d;
            osc_prev_q <= osc_prev_d;
        end
    end

    // APB decode
    always_comb begin
        setup   = PSEL_I & ~PENABLE_I;
        access  = PSEL_I & PENABLE_I & pready_q;
        wr      = access & PWRITE_I & ~pslverr_q;
        aligned = (PADDR_I[1:0] == 2'b00);
        hit     = aligned & ((PADDR_I == TRAP_CTRL_OFS) |
                             (PADDR_I == RESET_CAUSE_OFS) |
                             (PADDR_I == IRQ_STATUS_OFS) |
                             (PADDR_I == IRQ_ENABLE_OFS) |
                             (PADDR_I == IRQ_CLEAR_OFS));
        wr_trap  = wr & (PADDR_I == TRAP_CTRL_OFS);
        wr_cause = wr & (PADDR_I == RESET_CAUSE_OFS);
        wr_en    = wr & (PADDR_I == IRQ_ENABLE_OFS);
        wr_clr   = wr & (PADDR_I == IRQ_CLEAR_OFS);
        wdata16  = PWDATA_I[REG_W-1:0];
    end

    // Read data and response are prepared in the setup cycle
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup ? ~hit : pslverr_q;
        prdata_d  = prdata_q;
        if (setup) begin
            prdata_d = '0;
            if (aligned) begin
                case (PADDR_I)
                    TRAP_CTRL_OFS: begin
                        prdata_d[REG_W-1:0] = trap_q;
                    end
                    RESET_CAUSE_OFS: begin
                        prdata_d[REG_W-1:0] = cause_q;
                    end
                    IRQ_STATUS_OFS: begin
                        prdata_d[NUM_EVENTS-1:0] = ev_status;
                    end
                    IRQ_ENABLE_OFS: begin
                        prdata_d[NUM_EVENTS-1:0] = ev_enable;
                    end
                    default: begin
                        prdata_d = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Hardware set terms for the trap register
    always_comb begin
        trap_set = '0;
        trap_set[ACC_A_OVF_BIT] = ACC_A_OVF_I
                                & trap_q[ACC_A_TE_BIT]; // [RULE4]
        trap_set[ACC_B_OVF_BIT] = ACC_B_OVF_I & trap_q[ACC_B_TE_BIT];
        trap_set[ACC_A_CAT_BIT] = ACC_A_CAT_I & trap_q[CAT_TE_BIT]; // [RULE3]
        trap_set[ACC_B_CAT_BIT] = ACC_B_CAT_I & trap_q[CAT_TE_BIT];
        trap_set[SHIFT_ERR_BIT] = SHIFT_ERR_I; // [RULE5]
        trap_set[DIV_ZERO_BIT]  = DIV_ZERO_I; // [RULE6]
        trap_set[DMA_TRAP_BIT]  = DMA_TRAP_I; // [RULE2]
        trap_set[ADDR_ERR_BIT]  = ADDR_ERR_I;
        trap_set[STACK_ERR_BIT] = STACK_ERR_I;
        trap_set[OSC_FAIL_BIT]  = osc_rise;
        math_set = SHIFT_ERR_I | DIV_ZERO_I |
                   trap_set[ACC_A_OVF_BIT] | trap_set[ACC_B_OVF_BIT] |
                   trap_set[ACC_A_CAT_BIT] | trap_set[ACC_B_CAT_BIT];
        trap_set[MATH_ERR_BIT] = math_set;
    end

    // Flags hold until written to zero; a set beats the write
    always_comb begin
        trap_d = wr_trap ? (wdata16 & TRAP_CTRL_MASK) : trap_q; // [RULE1]
        trap_d = trap_d | trap_set; // [RULE14]
        trap_d[0] = 1'b0; // [RULE7]
        trap_req_d = |(trap_d & TRAP_FLAG_MASK);
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            trap_q     <= TRAP_CTRL_RESET; // [RULE7]
            trap_req_q <= 1'b0;
        end else begin
            trap_q     <= trap_d;
            trap_req_q <= trap_req_d;
        end
    end

    // Reset cause and wake flags; writes only store bits
    always_comb begin
        cause_d = wr_cause ? (wdata16 & RESET_CAUSE_MASK)
                           : cause_q; // [RULE12]
        if (SLEEP_WAKE_I) begin
            cause_d[SLEEP_BIT] = 1'b1; // [RULE8]
        end
        if (IDLE_WAKE_I) begin
            cause_d[IDLE_BIT] = 1'b1; // [RULE9]
        end
        if (bor_rise) begin
            cause_d[BROWNOUT_BIT] = 1'b1; // [RULE10]
        end
        wdt_en_d = wdt_cfg_lvl | cause_d[WDT_SW_EN_BIT]; // [RULE13]
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cause_q  <= RESET_CAUSE_RESET; // [RULE11]
            wdt_en_q <= 1'b1;
        end else begin
            cause_q  <= cause_d;
            wdt_en_q <= wdt_en_d;
        end
    end

    // Interrupt nesting control
    always_comb begin
        grant_d = 1'b0;
        if (IRQ_REQ_I) begin
            if (!IN_SERVICE_I) begin
                grant_d = 1'b1;
            end else if (!trap_q[NEST_DIS_BIT]) begin
                grant_d = (IRQ_PRIO_I > SERVICE_PRIO_I); // [RULE15]
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= grant_d;
        end
    end

    // Interrupt events
    always_comb begin
        ev_set              = '0;
        ev_set[EV_MATH]     = math_set;
        ev_set[EV_ADDR]     = ADDR_ERR_I;
        ev_set[EV_STACK]    = STACK_ERR_I;
        ev_set[EV_OSC]      = osc_rise;
        ev_set[EV_DMA]      = DMA_TRAP_I;
        ev_set[EV_BROWNOUT] = bor_rise;
        ev_set[EV_WAKE]     = SLEEP_WAKE_I | IDLE_WAKE_I;
    end

    event_irq #(
        .N (NUM_EVENTS)
    ) u_event_irq (
        .clk_i       (MCLK_I),
        .rst_n_i     (RESET_N_I),
        .set_i       (ev_set),
        .clear_wr_i  (wr_clr),
        .enable_wr_i (wr_en),
        .wdata_i     (PWDATA_I[NUM_EVENTS-1:0]),
        .status_o    (ev_status),
        .enable_o    (ev_enable),
        .irq_o       (irq_int)
    );

    assign PRDATA_O      = prdata_q;
    assign PREADY_O      = pready_q;
    assign PSLVERR_O     = pslverr_q;
    assign IRQ_GRANT_O   = grant_q;
    assign TRAP_REQ_O    = trap_req_q;
    assign WATCHDOG_EN_O = wdt_en_q;
    assign IRQ_O         = irq_int;

endmodule // trap_and_reset_status

//--- sim/trap_and_reset_status_properties.sv
// Port-level checker for the trap and reset status block
`timescale 1ns/1ps
module trap_and_reset_status_properties #(
    parameter int PRIO_W = 3
) (
    input wire logic              MCLK_I,
    input wire logic              RESET_N_I,
    input wire logic              PSEL_I,
    input wire logic              PENABLE_I,
    input wire logic              PWRITE_I,
    input wire logic              PREADY_O,
    input wire logic              SHIFT_ERR_I,
    input wire logic              DIV_ZERO_I,
    input wire logic              WDT_CONFIG_EN_I,
    input wire logic              IRQ_REQ_I,
    input wire logic [PRIO_W-1:0] IRQ_PRIO_I,
    input wire logic              IN_SERVICE_I,
    input wire logic [PRIO_W-1:0] SERVICE_PRIO_I,
    input wire logic              IRQ_GRANT_O,
    input wire logic              TRAP_REQ_O,
    input wire logic              WATCHDOG_EN_O,
    input wire logic              IRQ_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_ready_one_pulse: assert property (
        PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("ready did not pulse once after setup");
    a_div_zero_trap: assert property (
        DIV_ZERO_I |=> TRAP_REQ_O)
        else $error("divide by zero raised no trap");
    a_shift_err_trap: assert property (
        SHIFT_ERR_I |=> TRAP_REQ_O)
        else $error("shift error raised no trap");
    a_trap_stays_set: assert property (
        TRAP_REQ_O && !(PSEL_I && PWRITE_I) && !$past(PSEL_I && PWRITE_I)
        |=> TRAP_REQ_O)
        else $error("trap request dropped without a write");
    a_watchdog_forced: assert property (
        WDT_CONFIG_EN_I [*6] |=> WATCHDOG_EN_O)
        else $error("watchdog off while config forces it on");
    a_grant_when_free: assert property (
        IRQ_REQ_I && !IN_SERVICE_I |=> IRQ_GRANT_O)
        else $error("request not granted while idle");
    a_grant_held_off: assert property (
        IN_SERVICE_I && IRQ_PRIO_I <= SERVICE_PRIO_I |=> !IRQ_GRANT_O)
        else $error("grant to a request of no higher priority");
    a_no_request_grant: assert property (
        !IRQ_REQ_I |=> !IRQ_GRANT_O)
        else $error("grant without a request");

    c_irq_raised: cover property ($rose(IRQ_O));
    c_grant_seen: cover property ($rose(IRQ_GRANT_O));
    c_trap_seen: cover property ($rose(TRAP_REQ_O));
endmodule // trap_and_reset_status_properties

bind trap_and_reset_status trap_and_reset_status_properties #(
    .PRIO_W(PRIO_W)
) i_props (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O),
    .SHIFT_ERR_I(SHIFT_ERR_I), .DIV_ZERO_I(DIV_ZERO_I),
    .WDT_CONFIG_EN_I(WDT_CONFIG_EN_I), .IRQ_REQ_I(IRQ_REQ_I),
    .IRQ_PRIO_I(IRQ_PRIO_I), .IN_SERVICE_I(IN_SERVICE_I),
    .SERVICE_PRIO_I(SERVICE_PRIO_I), .IRQ_GRANT_O(IRQ_GRANT_O),
    .TRAP_REQ_O(TRAP_REQ_O), .WATCHDOG_EN_O(WATCHDOG_EN_O), .IRQ_O(IRQ_O)
);

//--- sim/trap_and_reset_status_test.sv
// Self-checking bench for the trap and reset status block
`timescale 1ns/1ps
module trap_and_reset_status_test;
    import trs_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, er;
    logic [12:0] ev = 13'h0;
    logic        wdt_cfg = 1'b1;
    logic        irq_req = 1'b0;
    logic        in_svc = 1'b0;
    logic [2:0]  irq_prio = 3'h0;
    logic [2:0]  svc_prio = 3'h0;
    logic        grant, trap_req, wd_en, irq;
    int          mismatches = 0;
    int          tests_run = 0;
    // Event masks, expected trap words, nesting rows
    logic [12:0] tev [8] = '{13'h10, 13'h20, 13'h40, 13'h80, 13'h100,
                             13'h200, 13'h1, 13'h4};
    logic [15:0] texp [8] = '{16'h90, 16'h50, 16'h20, 16'h8, 16'h4,
                              16'h2, 16'h0, 16'h0};
    logic [9:0]  nrow [6] = '{10'h09f, 10'h1d7, 10'h1b6, 10'h3f0,
                              10'h28f, 10'h070};

    always #5 clk = ~clk;

    trap_and_reset_status i_dut (
        .MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .ACC_A_OVF_I(ev[0]), .ACC_B_OVF_I(ev[1]),
        .ACC_A_CAT_I(ev[2]), .ACC_B_CAT_I(ev[3]), .SHIFT_ERR_I(ev[4]),
        .DIV_ZERO_I(ev[5]), .DMA_TRAP_I(ev[6]), .ADDR_ERR_I(ev[7]),
        .STACK_ERR_I(ev[8]), .OSC_FAIL_I(ev[9]), .BROWNOUT_I(ev[10]),
        .SLEEP_WAKE_I(ev[11]), .IDLE_WAKE_I(ev[12]),
        .WDT_CONFIG_EN_I(wdt_cfg), .IRQ_REQ_I(irq_req),
        .IRQ_PRIO_I(irq_prio), .IN_SERVICE_I(in_svc),
        .SERVICE_PRIO_I(svc_prio), .IRQ_GRANT_O(grant),
        .TRAP_REQ_O(trap_req), .WATCHDOG_EN_O(wd_en), .IRQ_O(irq)
    );

    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Ready and read data are taken at the rising edge ending the access
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: no ready", $time);
            conclude();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check32(rd, exp);
    endtask

    // Held six cycles so the pin filters accept it
    task automatic pulse(input logic [12:0] m);
        @(posedge clk);
        ev <= m;
        repeat (6) @(posedge clk);
        ev <= 13'h0;
        wait_cyc(8);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    initial begin
        do_reset();
        rdchk(TRAP_CTRL_OFS, 32'h0);
        rdchk(RESET_CAUSE_OFS, 32'h1);
        check1(wd_en, 1'b1);
        for (int i = 0; i < 8; i++) begin
            pulse(tev[i]);
            check1(trap_req, texp[i] != 16'h0);
            rdchk(TRAP_CTRL_OFS, {16'h0, texp[i]});
            wr(TRAP_CTRL_OFS, 32'h0);
            rdchk(TRAP_CTRL_OFS, 32'h0);
        end
        wr(TRAP_CTRL_OFS, 32'h0700);
        pulse(13'hf);
        rdchk(TRAP_CTRL_OFS, 32'h7f10);
        wr(TRAP_CTRL_OFS, 32'hffffffff);
        rdchk(TRAP_CTRL_OFS, 32'h0000fffe);
        wr(TRAP_CTRL_OFS, 32'h0);
        wr(IRQ_ENABLE_OFS, 32'h20);
        pulse(13'h800);
        rdchk(RESET_CAUSE_OFS, 32'h9);
        pulse(13'h1000);
        rdchk(RESET_CAUSE_OFS, 32'hd);
        pulse(13'h400);
        rdchk(RESET_CAUSE_OFS, 32'hf);
        check1(irq, 1'b1);
        wr(RESET_CAUSE_OFS, 32'h0);
        rdchk(RESET_CAUSE_OFS, 32'h0);
        wr(RESET_CAUSE_OFS, 32'hf);
        rdchk(RESET_CAUSE_OFS, 32'hf);
        rdchk(IRQ_ENABLE_OFS, 32'h20);
        @(posedge clk);
        wdt_cfg <= 1'b0;
        wait_cyc(8);
        check1(wd_en, 1'b0);
        wr(RESET_CAUSE_OFS, 32'h2f);
        wait_cyc(1);
        check1(wd_en, 1'b1);
        wr(RESET_CAUSE_OFS, 32'hf);
        @(posedge clk);
        wdt_cfg <= 1'b1;
        wait_cyc(8);
        check1(wd_en, 1'b1);
        wr(IRQ_CLEAR_OFS, 32'h7f);
        wr(IRQ_ENABLE_OFS, 32'h2);
        rdchk(IRQ_STATUS_OFS, 32'h0);
        pulse(13'h40);
        check1(irq, 1'b0);
        pulse(13'h80);
        check1(irq, 1'b1);
        wr(IRQ_STATUS_OFS, 32'h0);
        wr(IRQ_CLEAR_OFS, 32'h2);
        wait_cyc(1);
        check1(irq, 1'b0);
        rdchk(IRQ_STATUS_OFS, 32'h10);
        apb(1'b0, 12'h100, 32'h0);
        check1(er, 1'b1);
        check32(rd, 32'h0);
        apb(1'b1, 12'h002, 32'hffff);
        check1(er, 1'b1);
        rdchk(TRAP_CTRL_OFS, 32'h28);
        for (int i = 0; i < 6; i++) begin
            wr(TRAP_CTRL_OFS, {16'h0, nrow[i][9], 15'h0});
            @(posedge clk);
            in_svc <= nrow[i][8];
            irq_req <= nrow[i][7];
            irq_prio <= nrow[i][6:4];
            svc_prio <= nrow[i][3:1];
            wait_cyc(2);
            check1(grant, nrow[i][0]);
        end
        wr(TRAP_CTRL_OFS, 32'h8004);
        do_reset();
        rdchk(TRAP_CTRL_OFS, 32'h0);
        rdchk(RESET_CAUSE_OFS, 32'h1);
        conclude();
    end
endmodule // trap_and_reset_status_test
